// ### rtl/ispg_pkg.sv
// Constants shared by the image statistics and pixel grabber block
package ispg_pkg;
    localparam int unsigned SYS_CLK_MHZ  = 100;
    localparam int unsigned MAIN_CLK_MHZ = 24;
    localparam int unsigned ACC_W        = 7;
    localparam int unsigned ARRAY_SIDE   = 19;
    localparam int unsigned PIXEL_COUNT  = ARRAY_SIDE * ARRAY_SIDE;
    localparam int unsigned IDX_W        = 9;
    localparam int unsigned SUM_W        = 16;
    localparam int unsigned PIX_W        = 7;

    localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'(MAIN_CLK_MHZ);
    localparam logic [ACC_W-1:0] TICK_MOD  = ACC_W'(SYS_CLK_MHZ);
    localparam logic [IDX_W-1:0] LAST_IDX  = IDX_W'(PIXEL_COUNT - 1);
    localparam logic [IDX_W-1:0] FIRST_IDX = 9'h000;

    localparam logic [7:0] FEATURE_MAX = 8'h80;

    localparam logic [7:0] ADDR_FEATURE  = 8'h06;
    localparam logic [7:0] ADDR_EXP_HIGH = 8'h07;
    localparam logic [7:0] ADDR_EXP_LOW  = 8'h08;
    localparam logic [7:0] ADDR_BRIGHT   = 8'h09;
    localparam logic [7:0] ADDR_SUM      = 8'h0A;
    localparam logic [7:0] ADDR_DARK     = 8'h0B;
    localparam logic [7:0] ADDR_CAPTURE  = 8'h0C;

    localparam logic [15:0] RST_EXPOSURE = 16'h0064;
    localparam logic [7:0]  RST_FEATURE  = 8'h00;
    localparam logic [6:0]  RST_PIXEL    = 7'h00;
    localparam logic [7:0]  RST_SUM      = 8'h00;
    localparam logic [7:0]  READ_ZERO    = 8'h00;
    localparam logic [15:0] EXP_SAT      = 16'hFFFF;
    localparam logic [6:0]  PIX_FULL     = 7'h7F;

    typedef enum logic [1:0] {
        ISPG_IDLE,
        ISPG_WAIT,
        ISPG_ARMED,
        ISPG_HELD
    } ispg_grab_e;
endpackage : ispg_pkg

// ### rtl/ispg_tick.sv
// Fractional divider giving the main clock tick enable
`timescale 1ns/100ps
`default_nettype none
module ispg_tick
    import ispg_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rstn_i,
    output logic      tick_o
);
    logic [ACC_W-1:0] phase;
    logic [ACC_W:0]   next_phase;

    // Adds 24 per 100 MHz cycle and ticks on each wrap of 100
    always_comb begin
        next_phase = {1'b0, phase} + {1'b0, TICK_STEP};
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            phase  <= '0;
            tick_o <= 1'b0;
        end else if (next_phase >= {1'b0, TICK_MOD}) begin
            phase  <= ACC_W'(next_phase - {1'b0, TICK_MOD});
            tick_o <= 1'b1;
        end else begin
            phase  <= next_phase[ACC_W-1:0];
            tick_o <= 1'b0;
        end
    end
endmodule : ispg_tick
`default_nettype wire

// ### rtl/ispg_stats.sv
// Per-frame brightest, darkest and summed pixel values and pixel position
`timescale 1ns/100ps
`default_nettype none
module ispg_stats
    import ispg_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             frame_start_i,
    input  wire logic             pixel_valid_i,
    input  wire logic [PIX_W-1:0] pixel_data_i,
    output logic      [IDX_W-1:0] pixel_pos_o,
    output logic                  frame_done_o,
    output logic      [PIX_W-1:0] peak_value_bits_o,
    output logic      [PIX_W-1:0] floor_value_bits_o,
    output logic      [7:0]       sum_value_bits_o
);
    logic [PIX_W-1:0] run_max;
    logic [PIX_W-1:0] run_min;
    logic [SUM_W-1:0] run_sum;
    logic [PIX_W-1:0] new_max;
    logic [PIX_W-1:0] new_min;
    logic [SUM_W-1:0] new_sum;
    logic             last_pix;

    always_comb begin
        new_max  = (pixel_data_i > run_max) ? pixel_data_i : run_max;
        new_min  = (pixel_data_i < run_min) ? pixel_data_i : run_min;
        new_sum  = run_sum + SUM_W'(pixel_data_i);
        last_pix = pixel_valid_i && (pixel_pos_o == LAST_IDX);
    end

    // Running values restart at each frame start
    always_ff @(posedge clock_i) begin
        if (!rstn_i || frame_start_i) begin
            pixel_pos_o <= FIRST_IDX;
            run_max     <= '0;
            run_min     <= PIX_FULL;
            run_sum     <= '0;
        end else if (pixel_valid_i && !(pixel_pos_o > LAST_IDX)) begin
            pixel_pos_o <= pixel_pos_o + 9'h001;
            run_max     <= new_max;
            run_min     <= new_min;
            run_sum     <= new_sum;
        end
    end

    // Results taken when the last of the 361 pixels arrives
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            frame_done_o       <= 1'b0;
            peak_value_bits_o  <= RST_PIXEL;
            floor_value_bits_o <= RST_PIXEL;
            sum_value_bits_o   <= RST_SUM;
        end else begin
            frame_done_o <= last_pix && !frame_start_i;
            if (last_pix && !frame_start_i) begin
                peak_value_bits_o  <= new_max;
                floor_value_bits_o <= new_min;
                sum_value_bits_o   <= new_sum[15:8];
            end
        end
    end
endmodule : ispg_stats
`default_nettype wire

// ### rtl/ispg_top.sv
// Image statistics test registers with single pixel grabber
// Summary of operation
// - Report feature count, clipped to 128
// - Exposure split into high and low bytes
// - Exposure counts main clock ticks while open
// - Brightest pixel in bits 6..0, bit 7 zero
// - Darkest pixel in bits 6..0, bit 7 zero
// - Pixel sum bits 15..8 exposed
// - Capture at most one pixel per frame
// - Valid read returns flag, advances, re-arms
// - 361 valid reads give whole image
// - A write to the capture register resets index and arms
// - Index follows imager readout order
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ispg_top
    import ispg_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_write_i,
    input  wire logic             reg_read_i,
    output logic      [7:0]       reg_rdata_o,
    input  wire logic             frame_start_i,
    input  wire logic             pixel_valid_i,
    input  wire logic [PIX_W-1:0] pixel_data_i,
    input  wire logic             shutter_open_i,
    input  wire logic [7:0]       surface_feature_count_i,
    output logic                  frame_done_o,
    output logic                  main_tick_o
);
    logic             tick;
    logic [IDX_W-1:0] pixel_pos;
    logic             frame_done;
    logic [PIX_W-1:0] peak_value_bits;
    logic [PIX_W-1:0] floor_value_bits;
    logic [7:0]       sum_value_bits;

    logic [7:0]       surface_feature_count;
    logic [15:0]      exposure;
    logic [15:0]      exposure_run;
    logic             shutter_prev;
    logic [7:0]       exposure_low_frozen;
    logic             low_frozen;

    ispg_grab_e       grab_state;
    ispg_grab_e       next_grab_state;
    logic [IDX_W-1:0] grab_index;
    logic [IDX_W-1:0] next_grab_index;
    logic [PIX_W-1:0] captured_pixel_value;
    logic             grab_hit;

    logic             rd_capture;
    logic             wr_capture;
    logic             rd_high;
    logic             rd_low;
    logic [7:0]       next_rdata;

    // Compares a bus address with a register offset
    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        addr_is = (addr == offset);
    endfunction : addr_is

    // Clips the feature count to its documented ceiling
    function automatic logic [7:0] clip_features(
        input logic [7:0] count
    );
        clip_features = (count > FEATURE_MAX) ? FEATURE_MAX : count;
    endfunction : clip_features

    ispg_tick u_tick (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .tick_o  (tick)
    );

    ispg_stats u_stats (
        .clock_i            (clock_i),
        .rstn_i             (rstn_i),
        .frame_start_i      (frame_start_i),
        .pixel_valid_i      (pixel_valid_i),
        .pixel_data_i       (pixel_data_i),
        .pixel_pos_o        (pixel_pos),
        .frame_done_o       (frame_done),
        .peak_value_bits_o  (peak_value_bits),
        .floor_value_bits_o (floor_value_bits),
        .sum_value_bits_o   (sum_value_bits)
    );

    assign frame_done_o = frame_done;
    assign main_tick_o  = tick;

    // Bus decode
    always_comb begin
        rd_capture = reg_read_i && addr_is(reg_addr_i, ADDR_CAPTURE);
        wr_capture = reg_write_i && addr_is(reg_addr_i, ADDR_CAPTURE);
        rd_high    = reg_read_i && addr_is(reg_addr_i, ADDR_EXP_HIGH);
        rd_low     = reg_read_i && addr_is(reg_addr_i, ADDR_EXP_LOW);
    end

    // Feature count taken once per completed frame
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            surface_feature_count <= RST_FEATURE;
        end else if (frame_done) begin
            surface_feature_count <= clip_features(surface_feature_count_i);
        end
    end

    // Shutter edge tracking
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            shutter_prev <= 1'b0;
        end else begin
            shutter_prev <= shutter_open_i;
        end
    end

    // Open time counted in main clock ticks, saturating
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            exposure_run <= '0;
        end else if (shutter_open_i && !shutter_prev) begin
            exposure_run <= '0;
        end else if (shutter_open_i && tick && exposure_run != EXP_SAT) begin
            exposure_run <= exposure_run + 16'h0001;
        end
    end

    // Exposure of the last image, latched as the shutter closes
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            exposure <= RST_EXPOSURE;
        end else if (!shutter_open_i && shutter_prev) begin
            exposure <= exposure_run;
        end
    end

    // High byte read holds the matching low byte until it is read
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            low_frozen          <= 1'b0;
            exposure_low_frozen <= RST_EXPOSURE[7:0];
        end else if (rd_high) begin
            low_frozen          <= 1'b1;
            exposure_low_frozen <= exposure[7:0];
        end else if (rd_low) begin
            low_frozen <= 1'b0;
        end
    end

    // Grabber hits when the stream reaches the selected pixel
    always_comb begin
        grab_hit = pixel_valid_i && (pixel_pos == grab_index) && !frame_start_i;
    end

    // Grabber sequencing
    always_comb begin
        next_grab_state = grab_state;
        next_grab_index = grab_index;
        if (wr_capture) begin
            next_grab_state = ISPG_WAIT;
            next_grab_index = FIRST_IDX;
        end else begin
            unique case (grab_state)
                ISPG_IDLE: begin
                    next_grab_state = ISPG_WAIT;
                end
                ISPG_WAIT: begin
                    if (frame_start_i) begin
                        next_grab_state = ISPG_ARMED;
                    end
                end
                ISPG_ARMED: begin
                    if (grab_hit) begin
                        next_grab_state = ISPG_HELD;
                    end else if (frame_start_i) begin
                        next_grab_state = ISPG_ARMED;
                    end
                end
                ISPG_HELD: begin
                    if (rd_capture) begin
                        next_grab_state = ISPG_WAIT;
                        if (grab_index == LAST_IDX) begin
                            next_grab_index = FIRST_IDX;
                        end else begin
                            next_grab_index = grab_index + 9'h001;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            grab_state <= ISPG_IDLE;
            grab_index <= FIRST_IDX;
        end else begin
            grab_state <= next_grab_state;
            grab_index <= next_grab_index;
        end
    end

    // One pixel kept per arming, so never more than one per frame
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            captured_pixel_value <= RST_PIXEL;
        end else if (grab_state == ISPG_ARMED && grab_hit && !wr_capture) begin
            captured_pixel_value <= pixel_data_i;
        end
    end

    // Read data mux
    always_comb begin
        next_rdata = READ_ZERO;
        if (addr_is(reg_addr_i, ADDR_FEATURE)) begin
            next_rdata = surface_feature_count;
        end else if (addr_is(reg_addr_i, ADDR_EXP_HIGH)) begin
            next_rdata = exposure[15:8];
        end else if (addr_is(reg_addr_i, ADDR_EXP_LOW)) begin
            next_rdata = low_frozen ? exposure_low_frozen : exposure[7:0];
        end else if (addr_is(reg_addr_i, ADDR_BRIGHT)) begin
            next_rdata = {1'b0, peak_value_bits};
        end else if (addr_is(reg_addr_i, ADDR_SUM)) begin
            next_rdata = sum_value_bits;
        end else if (addr_is(reg_addr_i, ADDR_DARK)) begin
            next_rdata = {1'b0, floor_value_bits};
        end else if (addr_is(reg_addr_i, ADDR_CAPTURE)) begin
            if (grab_state == ISPG_HELD) begin
                next_rdata = {1'b1, captured_pixel_value};
            end else begin
                next_rdata = READ_ZERO;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= READ_ZERO;
        end else if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= READ_ZERO;
        end
    end
endmodule : ispg_top
`default_nettype wire

// ### testbench/ispg_monitor.sv
// Port checker for the image statistics and pixel grabber block
`timescale 1ns/100ps
`default_nettype none
module ispg_monitor
    import ispg_pkg::*;
(
    input wire logic             clock_i,
    input wire logic             rstn_i,
    input wire logic [7:0]       reg_addr_i,
    input wire logic [7:0]       reg_wdata_i,
    input wire logic             reg_write_i,
    input wire logic             reg_read_i,
    input wire logic [7:0]       reg_rdata_o,
    input wire logic             frame_start_i,
    input wire logic             pixel_valid_i,
    input wire logic [PIX_W-1:0] pixel_data_i,
    input wire logic             shutter_open_i,
    input wire logic [7:0]       surface_feature_count_i,
    input wire logic             frame_done_o,
    input wire logic             main_tick_o
);
    logic rd_cap_q;
    logic grab_seen;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // Capture read in flight, and a valid grab seen since the last frame start
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rd_cap_q  <= 1'b0;
            grab_seen <= 1'b0;
        end else begin
            rd_cap_q <= reg_read_i && reg_addr_i == ADDR_CAPTURE;
            if (frame_start_i) begin
                grab_seen <= 1'b0;
            end else if (rd_cap_q && reg_rdata_o[7]) begin
                grab_seen <= 1'b1;
            end
        end
    end

    AST_FEATURE_MAX: assert property ((reg_read_i && reg_addr_i == ADDR_FEATURE) |=> reg_rdata_o <= FEATURE_MAX)
        else $error("feature count above limit");
    AST_BRIGHT_MSB: assert property ((reg_read_i && reg_addr_i == ADDR_BRIGHT) |=> !reg_rdata_o[7])
        else $error("brightest pixel bit 7 set");
    AST_DARK_MSB: assert property ((reg_read_i && reg_addr_i == ADDR_DARK) |=> reg_rdata_o[7] == 1'b0)
        else $error("darkest pixel bit 7 set");
    AST_EMPTY_GRAB: assert property ((reg_read_i && reg_addr_i == ADDR_CAPTURE) |=>
        (reg_rdata_o[7] || reg_rdata_o == READ_ZERO)) else $error("empty grab read not zero");
    AST_WRITE_CLEARS: assert property ((reg_write_i && reg_addr_i == ADDR_CAPTURE) ##[1:2]
        (reg_read_i && reg_addr_i == ADDR_CAPTURE) |=> reg_rdata_o == READ_ZERO) else $error("grab held after write");
    AST_GRAB_ONCE: assert property ((rd_cap_q && reg_rdata_o[7]) |-> !grab_seen)
        else $error("second grab without a new frame");
    AST_TICK_SPACING: assert property (main_tick_o |=> !main_tick_o [*3] ##[1:2] main_tick_o)
        else $error("main tick spacing wrong");
    AST_DONE_PULSE: assert property ($rose(frame_done_o) |=> !frame_done_o [*8])
        else $error("frame done repeated too soon");

    COV_VALID_GRAB: cover property (rd_cap_q && reg_rdata_o[7]);
    COV_FRAME_DONE: cover property (frame_done_o);
    COV_GRAB_WRITE: cover property (reg_write_i && reg_addr_i == ADDR_CAPTURE);
endmodule : ispg_monitor

bind ispg_top ispg_monitor ispg_monitor_inst (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .frame_start_i(frame_start_i), .pixel_valid_i(pixel_valid_i), .pixel_data_i(pixel_data_i),
    .shutter_open_i(shutter_open_i), .surface_feature_count_i(surface_feature_count_i),
    .frame_done_o(frame_done_o), .main_tick_o(main_tick_o));
`default_nettype wire

// ### testbench/ispg_top_tb_top.sv
// Self-checking testbench for the image statistics and pixel grabber block
`timescale 1ns/100ps
`default_nettype none
module ispg_top_tb_top
    import ispg_pkg::*;
;
    logic             clock_i = 1'b0;
    logic             rstn_i = 1'b0;
    logic [7:0]       reg_addr_i = 8'h00;
    logic [7:0]       reg_wdata_i = 8'h00;
    logic             reg_write_i = 1'b0;
    logic             reg_read_i = 1'b0;
    logic [7:0]       reg_rdata_o;
    logic             frame_start_i = 1'b0;
    logic             pixel_valid_i = 1'b0;
    logic [PIX_W-1:0] pixel_data_i = 7'h00;
    logic             shutter_open_i = 1'b0;
    logic [7:0]       surface_feature_count_i = 8'h00;
    logic             frame_done_o;
    logic             main_tick_o;
    int               miscompares = 0;
    int               num_checks = 0;
    int               cycles = 0;
    logic [7:0]       rdv;
    logic [15:0]      expo;
    logic [15:0]      rst_rows [9] = '{16'h0600, 16'h0700, 16'h0864, 16'h0900, 16'h0A00, 16'h0B00,
                                       16'h0C00, 16'h0D00, 16'h3F00};

    ispg_top ispg_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .frame_start_i(frame_start_i), .pixel_valid_i(pixel_valid_i), .pixel_data_i(pixel_data_i),
        .shutter_open_i(shutter_open_i), .surface_feature_count_i(surface_feature_count_i),
        .frame_done_o(frame_done_o), .main_tick_o(main_tick_o));

    always #5 clock_i = ~clock_i;

    task automatic results();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= a ^ 8'h5A;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1 rdv = reg_rdata_o;
    endtask : rd

    function automatic logic [6:0] pix(input int i, input int f);
        return 7'((i * 5 + f * 13) % 97 + f);
    endfunction : pix

    // One whole frame, then the statistics registers against a running model
    task automatic frame(input int f, input logic [7:0] feat);
        logic [6:0]  mx;
        logic [6:0]  mn;
        logic [15:0] sm;
        int          w;
        mx = 7'h00;
        mn = 7'h7F;
        sm = 16'h0000;
        @(posedge clock_i);
        surface_feature_count_i <= feat;
        frame_start_i <= 1'b1;
        @(posedge clock_i);
        frame_start_i <= 1'b0;
        for (int i = 0; i < PIXEL_COUNT; i++) begin
            mx = (pix(i, f) > mx) ? pix(i, f) : mx;
            mn = (pix(i, f) < mn) ? pix(i, f) : mn;
            sm = sm + 16'(pix(i, f));
            pixel_valid_i <= 1'b1;
            pixel_data_i  <= pix(i, f);
            @(posedge clock_i);
        end
        pixel_valid_i <= 1'b0;
        w = 0;
        #1;
        while (frame_done_o !== 1'b1 && w < 20) begin
            @(posedge clock_i);
            #1;
            w++;
        end
        chk(16'(w), 16'h0000);
        repeat (2) @(posedge clock_i);
        rd(ADDR_BRIGHT);
        chk({8'h00, rdv}, {9'h000, mx});
        rd(ADDR_DARK);
        chk({8'h00, rdv}, {9'h000, mn});
        rd(ADDR_SUM);
        chk({8'h00, rdv}, {8'h00, sm[15:8]});
        rd(ADDR_FEATURE);
        chk({8'h00, rdv}, {8'h00, (feat > FEATURE_MAX) ? FEATURE_MAX : feat});
    endtask : frame

    task automatic shut(input int n);
        @(posedge clock_i);
        shutter_open_i <= 1'b1;
        repeat (n) @(posedge clock_i);
        shutter_open_i <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask : shut

    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        foreach (rst_rows[k]) begin
            rd(rst_rows[k][15:8]);
            chk({8'h00, rdv}, {8'h00, rst_rows[k][7:0]});
        end
        // Grabber walk: restart, single grabs, held pixel across frames
        wr(ADDR_CAPTURE);
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, 16'h0000);
        frame(1, 8'hC8);
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, {8'h00, 1'b1, pix(0, 1)});
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, 16'h0000);
        frame(2, 8'h80);
        frame(3, 8'h37);
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, {8'h00, 1'b1, pix(1, 2)});
        frame(4, 8'h81);
        wr(ADDR_CAPTURE);
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, 16'h0000);
        frame(5, 8'h00);
        rd(ADDR_CAPTURE);
        chk({8'h00, rdv}, {8'h00, 1'b1, pix(0, 5)});
        wr(ADDR_BRIGHT);
        rd(ADDR_BRIGHT);
        chk({8'h00, rdv}, 16'd101);
        // Exposure: 1200 open cycles give 288 ticks, then a frozen pair
        shut(1200);
        rd(ADDR_EXP_HIGH);
        expo[15:8] = rdv;
        rd(ADDR_EXP_LOW);
        expo[7:0] = rdv;
        chk(16'(expo >= 16'd287 && expo <= 16'd289), 16'h0001);
        chk({8'h00, expo[15:8]}, 16'h0001);
        rd(ADDR_EXP_HIGH);
        shut(400);
        rd(ADDR_EXP_LOW);
        chk({8'h00, rdv}, {8'h00, expo[7:0]});
        rd(ADDR_EXP_HIGH);
        expo[15:8] = rdv;
        rd(ADDR_EXP_LOW);
        expo[7:0] = rdv;
        chk(16'(expo >= 16'd95 && expo <= 16'd97), 16'h0001);
        results();
    end
endmodule : ispg_top_tb_top
`default_nettype wire
